// ===== status_pkg.sv
// Behaviour
// - Operation complete sets event bit 0 (bus)
// - Empty-queue read or lost data sets bit 2 (bus)
// - Unexecutable recognised command sets bit 4, dropped
// - Unparsable command line sets bit 5, dropped
// - Power-on transition sets event bit 7
// - Event query returns value, then clears all
// - Condition bit 4 high while measuring
// - Bit 8 set on initiated result, fetch clears
// - Operation event read clears; others read unchanged
// - Enabled status byte bit raises RQS, SRQ, bus only
// - Serial poll returns byte, clears RQS, SRQ
// - Bit 3 follows enabled questionable summary
// - Bit 4 while queue holds data, bus only
// - Bit 5 follows enabled standard events
// - Poll bit 6 is RQS, once per reason
// - Query bit 6 is MSS, bus only
// - Bit 7 follows enabled operation events
// - Clear-status clears events, summary, completion states
// - Completion command pending; serial link errors
// - Completion query pushes '1'; serial link errors
// - Only enabled bits reach the summary
// - Event latches condition rising edge; reads harmless
package status_pkg;

  // Command codes from the parser
  typedef enum logic [3:0] {
    CMD_NONE      = 4'b0000,
    CMD_ESR_Q     = 4'b0001,
    CMD_ESE_W     = 4'b0010,
    CMD_ESE_Q     = 4'b0011,
    CMD_OCOND_Q   = 4'b0100,
    CMD_OEVT_Q    = 4'b0101,
    CMD_OEN_W     = 4'b0110,
    CMD_OEN_Q     = 4'b0111,
    CMD_STB_Q     = 4'b1000,
    CMD_SRE_W     = 4'b1001,
    CMD_SRE_Q     = 4'b1010,
    CMD_CLS       = 4'b1011,
    CMD_OPC       = 4'b1100,
    CMD_OPC_Q     = 4'b1101
  } cmd_type;

  localparam int STD_W = 8;
  localparam int OPER_W = 16;

  // Standard event bit positions
  localparam int SE_OPC = 0;
  localparam int SE_QYE = 2;
  localparam int SE_EXE = 4;
  localparam int SE_CME = 5;
  localparam int SE_PON = 7;
  localparam logic [7:0] SE_USED = 8'hB5;

  // Operation bit positions
  localparam int OP_MEAS = 4;
  localparam int OP_AVAIL = 8;
  localparam logic [15:0] OP_USED = 16'h0110;

  // Status byte bit positions
  localparam int SB_QUES = 3;
  localparam int SB_MAV = 4;
  localparam int SB_ESB = 5;
  localparam int SB_RQS = 6;
  localparam int SB_OPER = 7;

  // Reset values
  localparam logic [7:0] SE_RST = 8'h80;
  localparam logic [7:0] SE_MASK_RST = 8'h00;
  localparam logic [15:0] OP_RST = 16'h0000;
  localparam logic [7:0] SRE_RST = 8'h00;

  // Reply character placed in the output queue after completion query
  localparam logic [7:0] OPC_REPLY = 8'h31;

endpackage

// ===== event_if.sv
// One event register group: set pulses in, latched flags and summary out
interface event_if #(parameter int W = 8);
  logic [W-1:0] set_bits;
  logic [W-1:0] mask;
  logic         clear;
  logic [W-1:0] flags;
  logic         summary;

  modport owner (input set_bits, input mask, input clear, output flags, output summary);
  modport user  (output set_bits, output mask, output clear, input flags, input summary);
endinterface

// ===== event_latch.sv
module event_latch #(
  parameter int           W       = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  event_if.owner   ev
);

  logic [W-1:0] flags_r;

  // Sticky flags; a set in the clearing cycle survives the clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flags_r <= RST_VAL;
    end else if (ev.clear) begin
      flags_r <= ev.set_bits;
    end else begin
      flags_r <= flags_r | ev.set_bits;
    end
  end

  // Summary drops at once when the mask bits are cleared
  assign ev.flags = flags_r;
  assign ev.summary = |(flags_r & ev.mask);

  property p_set_sticks;
    @(posedge sys_clk) disable iff (sys_rst)
      (ev.set_bits != '0) |=> ((ev.flags & $past(ev.set_bits)) == $past(ev.set_bits));
  endproperty
  a_set_sticks: assert property (p_set_sticks) else $error("event set was lost");

endmodule

// ===== status_reporting_service_request.sv
module status_reporting_service_request
  import status_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        ieee_mode,
  input  wire logic        cmd_valid,
  input  wire cmd_type     cmd_code,
  input  wire logic [15:0] cmd_data,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data,
  input  wire logic        exec_error,
  input  wire logic        parse_error,
  input  wire logic        oq_read_empty,
  input  wire logic        oq_data_lost,
  input  wire logic        oq_has_data,
  input  wire logic        ops_idle,
  input  wire logic        meas_start,
  input  wire logic        meas_done,
  input  wire logic        meas_by_init,
  input  wire logic        fetch_done,
  input  wire logic        ques_summary,
  input  wire logic        poll_req,
  output logic             poll_valid,
  output logic [7:0]       poll_data,
  output logic             srq,
  output logic             opc_push,
  output logic [7:0]       opc_push_data
);

  event_if #(.W(STD_W))  std_ev ();
  event_if #(.W(OPER_W)) op_ev ();

  logic [7:0]  std_mask_r;
  logic [15:0] op_mask_r;
  logic [15:0] op_cond_r;
  logic [15:0] op_cond_prev_r;
  logic [7:0]  sre_r;
  logic        opc_cmd_pend_r;
  logic        opc_qry_pend_r;
  logic        rqs_r;
  logic [7:0]  req_prev_r;
  logic [7:0]  summary_byte;
  logic [7:0]  req_bits;
  logic        cmd_cls;
  logic        cmd_opc_serial;
  logic        opc_fire;
  logic        opcq_fire;
  logic [7:0]  std_set;

  // Any bit common to two vectors
  function automatic logic any_common(input logic [7:0] a, input logic [7:0] b);
    return |(a & b);
  endfunction

  // Pulse qualified by a command code
  function automatic logic is_cmd(input logic v, input cmd_type c, input cmd_type want);
    return v && (c == want);
  endfunction

  assign cmd_cls = is_cmd(cmd_valid, cmd_code, CMD_CLS);

  // Completion commands are bus only; on the serial link they become parse errors
  assign cmd_opc_serial = !ieee_mode
                          && (is_cmd(cmd_valid, cmd_code, CMD_OPC)
                              || is_cmd(cmd_valid, cmd_code, CMD_OPC_Q));

  // Pending completion fires once nothing is in progress; clear-status cancels
  assign opc_fire  = opc_cmd_pend_r && ops_idle && !cmd_cls;
  assign opcq_fire = opc_qry_pend_r && ops_idle && !cmd_cls;

  // Standard event set sources
  always_comb begin
    std_set = 8'h00;
    std_set[SE_OPC] = opc_fire && ieee_mode;
    std_set[SE_QYE] = (oq_read_empty || oq_data_lost) && ieee_mode;
    std_set[SE_EXE] = exec_error;
    std_set[SE_CME] = parse_error || cmd_opc_serial;
  end

  // Standard event register; power-on bit set by the reset value
  assign std_ev.set_bits = std_set & SE_USED;
  assign std_ev.mask = std_mask_r;
  assign std_ev.clear = is_cmd(cmd_valid, cmd_code, CMD_ESR_Q) || cmd_cls;

  event_latch #(.W(STD_W), .RST_VAL(SE_RST)) u_std_event (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .ev      (std_ev)
  );

  // Operation condition: measuring and result-available levels
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      op_cond_r <= OP_RST;
    end else begin
      if (meas_start) begin
        op_cond_r[OP_MEAS] <= 1'b1;
      end else if (meas_done) begin
        op_cond_r[OP_MEAS] <= 1'b0;
      end
      if (meas_done && meas_by_init) begin
        op_cond_r[OP_AVAIL] <= 1'b1;
      end else if (fetch_done) begin
        op_cond_r[OP_AVAIL] <= 1'b0;
      end
    end
  end

  // Previous condition for rising-edge detection
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      op_cond_prev_r <= OP_RST;
    end else begin
      op_cond_prev_r <= op_cond_r;
    end
  end

  // Operation event register latches rising condition edges only
  assign op_ev.set_bits = op_cond_r & ~op_cond_prev_r & OP_USED;
  assign op_ev.mask = op_mask_r;
  assign op_ev.clear = is_cmd(cmd_valid, cmd_code, CMD_OEVT_Q) || cmd_cls;

  event_latch #(.W(OPER_W), .RST_VAL(OP_RST)) u_oper_event (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .ev      (op_ev)
  );

  // Mask registers written by the host
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      std_mask_r <= SE_MASK_RST;
      op_mask_r <= OP_RST;
      sre_r <= SRE_RST;
    end else if (cmd_valid) begin
      if (cmd_code == CMD_ESE_W) begin
        std_mask_r <= cmd_data[7:0] & SE_USED;
      end
      if (cmd_code == CMD_OEN_W) begin
        op_mask_r <= cmd_data & OP_USED;
      end
      if (cmd_code == CMD_SRE_W) begin
        // Bit 6 cannot request service about itself
        sre_r <= cmd_data[7:0] & ~(8'h01 << SB_RQS);
      end
    end
  end

  // Summary bits, live so that reads and mask writes drop them at once
  always_comb begin
    summary_byte = 8'h00;
    summary_byte[SB_QUES] = ques_summary;
    summary_byte[SB_MAV] = oq_has_data && ieee_mode;
    summary_byte[SB_ESB] = std_ev.summary;
    summary_byte[SB_OPER] = op_ev.summary;
  end

  assign req_bits = summary_byte & sre_r;

  // Previous request bits, to spot a new reason for service
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      req_prev_r <= 8'h00;
    end else begin
      req_prev_r <= req_bits;
    end
  end

  // RQS: set on a new reason, cleared by poll, on the serial link or when no reason remains
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rqs_r <= 1'b0;
    end else if (!ieee_mode || !any_common(summary_byte, sre_r)) begin
      rqs_r <= 1'b0;
    end else if (any_common(req_bits, ~req_prev_r)) begin
      rqs_r <= 1'b1;
    end else if (poll_req) begin
      rqs_r <= 1'b0;
    end
  end

  assign srq = rqs_r;

  // Serial poll answer carries RQS in bit 6
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      poll_valid <= 1'b0;
      poll_data <= 8'h00;
    end else begin
      poll_valid <= poll_req;
      if (poll_req) begin
        poll_data <= summary_byte | ({7'h00, rqs_r} << SB_RQS);
      end
    end
  end

  // Completion tracking states
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      opc_cmd_pend_r <= 1'b0;
      opc_qry_pend_r <= 1'b0;
    end else if (cmd_cls) begin
      opc_cmd_pend_r <= 1'b0;
      opc_qry_pend_r <= 1'b0;
    end else begin
      if (ieee_mode && is_cmd(cmd_valid, cmd_code, CMD_OPC)) begin
        opc_cmd_pend_r <= 1'b1;
      end else if (opc_fire) begin
        opc_cmd_pend_r <= 1'b0;
      end
      if (ieee_mode && is_cmd(cmd_valid, cmd_code, CMD_OPC_Q)) begin
        opc_qry_pend_r <= 1'b1;
      end else if (opcq_fire) begin
        opc_qry_pend_r <= 1'b0;
      end
    end
  end

  // Reply character to the output queue; its arrival raises the queue bit
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      opc_push <= 1'b0;
      opc_push_data <= 8'h00;
    end else begin
      opc_push <= opcq_fire && ieee_mode;
      opc_push_data <= OPC_REPLY;
    end
  end

  // Query answers; event values are sampled before their clear lands
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      if (cmd_valid) begin
        rsp_valid <= 1'b1;
        unique case (cmd_code)
          CMD_ESR_Q:   rsp_data <= {8'h00, std_ev.flags};
          CMD_ESE_Q:   rsp_data <= {8'h00, std_mask_r};
          CMD_OCOND_Q: rsp_data <= op_cond_r;
          CMD_OEVT_Q:  rsp_data <= op_ev.flags;
          CMD_OEN_Q:   rsp_data <= op_mask_r;
          CMD_STB_Q: begin
            rsp_data <= {8'h00, summary_byte
                         | ({7'h00, ieee_mode && (req_bits != 8'h00)} << SB_RQS)};
          end
          CMD_SRE_Q:   rsp_data <= {8'h00, sre_r};
          default:     rsp_valid <= 1'b0;
        endcase
      end
    end
  end

  property p_esr_clears;
    @(posedge sys_clk) disable iff (sys_rst)
      (cmd_valid && cmd_code == CMD_ESR_Q && std_ev.set_bits == 8'h00)
        |=> (std_ev.flags == 8'h00);
  endproperty
  a_esr_clears: assert property (p_esr_clears) else $error("event read did not clear");

  property p_esr_reply;
    @(posedge sys_clk) disable iff (sys_rst)
      (cmd_valid && cmd_code == CMD_ESR_Q) |=> (rsp_valid && rsp_data[7:0] == $past(std_ev.flags));
  endproperty
  a_esr_reply: assert property (p_esr_reply) else $error("event query reply wrong");

  property p_power_on;
    @(posedge sys_clk) $fell(sys_rst) |-> std_ev.flags[SE_PON];
  endproperty
  a_power_on: assert property (p_power_on) else $error("power-on flag missing");

  property p_measuring;
    @(posedge sys_clk) disable iff (sys_rst)
      (meas_start && !op_cond_r[OP_MEAS])
        |=> op_cond_r[OP_MEAS] ##1 (op_ev.flags[OP_MEAS] || op_ev.clear);
  endproperty
  a_measuring: assert property (p_measuring) else $error("measuring not flagged");

  property p_fetch_clears;
    @(posedge sys_clk) disable iff (sys_rst)
      (fetch_done && !(meas_done && meas_by_init)) |=> !op_cond_r[OP_AVAIL];
  endproperty
  a_fetch_clears: assert property (p_fetch_clears) else $error("fetch left result flag");

  property p_srq_follows;
    @(posedge sys_clk) disable iff (sys_rst)
      srq |-> ($past(ieee_mode) && ($past(req_bits) != 8'h00));
  endproperty
  a_srq_follows: assert property (p_srq_follows) else $error("service request without reason");

  property p_new_reason;
    @(posedge sys_clk) disable iff (sys_rst)
      (ieee_mode && (req_bits & ~req_prev_r) != 8'h00) |=> srq || (req_bits == 8'h00);
  endproperty
  a_new_reason: assert property (p_new_reason) else $error("new reason not requested");

  property p_poll_clears;
    @(posedge sys_clk) disable iff (sys_rst)
      (poll_req && rqs_r && (req_bits & ~req_prev_r) == 8'h00)
        |=> !srq ##0 poll_valid && poll_data[SB_RQS];
  endproperty
  a_poll_clears: assert property (p_poll_clears) else $error("poll did not release request");

  property p_serial_mav;
    @(posedge sys_clk) disable iff (sys_rst)
      !ieee_mode |-> !summary_byte[SB_MAV] ##1 !srq;
  endproperty
  a_serial_mav: assert property (p_serial_mav) else $error("bus-only bits on serial link");

  property p_opc_serial;
    @(posedge sys_clk) disable iff (sys_rst)
      (cmd_valid && cmd_code == CMD_OPC && !ieee_mode && !cmd_cls)
        |=> std_ev.flags[SE_CME] && !opc_cmd_pend_r;
  endproperty
  a_opc_serial: assert property (p_opc_serial) else $error("serial completion not refused");

  property p_opcq_push;
    @(posedge sys_clk) disable iff (sys_rst)
      (opc_qry_pend_r && ops_idle && ieee_mode && !cmd_cls)
        |=> opc_push && opc_push_data == OPC_REPLY;
  endproperty
  a_opcq_push: assert property (p_opcq_push) else $error("completion reply not pushed");

  property p_cls;
    @(posedge sys_clk) disable iff (sys_rst)
      cmd_cls |=> !opc_cmd_pend_r && !opc_qry_pend_r && op_ev.flags == $past(op_ev.set_bits);
  endproperty
  a_cls: assert property (p_cls) else $error("clear-status incomplete");

  property p_op_width;
    @(posedge sys_clk) disable iff (sys_rst)
      ((op_ev.flags | op_mask_r | op_cond_r) & ~OP_USED) == 16'h0000;
  endproperty
  a_op_width: assert property (p_op_width) else $error("undefined operation bit set");

  property p_ese_summary;
    @(posedge sys_clk) disable iff (sys_rst)
      (cmd_valid && cmd_code == CMD_ESR_Q && std_ev.set_bits == 8'h00)
        |=> !summary_byte[SB_ESB];
  endproperty
  a_ese_summary: assert property (p_ese_summary) else $error("standard summary wrong");

endmodule

// ===== host_ctrl_model.sv
module host_ctrl_model (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       srq,
  input  wire logic       opc_push,
  input  wire logic       auto_poll,
  input  wire logic [3:0] delay,
  input  wire logic       poll_now,
  input  wire logic       oq_flush,
  output logic            poll_req,
  output logic            oq_has_data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [4:0] cnt;
  logic       polled;

  // Serial poll, prompt or late; one poll per request so a stale srq is not polled twice
  always @(posedge sys_clk) begin
    poll_req <= !sys_rst && (cnt == 5'd1);
    if (sys_rst) begin
      cnt    <= '0;
      polled <= 1'b0;
    end else if (cnt == 5'd1) begin
      polled   <= 1'b1;
      cnt      <= '0;
    end else if (cnt != 5'd0) begin
      cnt <= cnt - 5'd1;
    end else if (poll_now || (auto_poll && srq && !polled)) begin
      cnt <= {1'b0, delay} + 5'd1;
    end else if (!srq) begin
      polled <= 1'b0;
    end
  end

  // Output queue: a pushed reply stays until the host reads it
  always @(posedge sys_clk) begin
    if (sys_rst) oq_has_data <= 1'b0;
    else if (opc_push) oq_has_data <= 1'b1;
    else if (oq_flush) oq_has_data <= 1'b0;
  end
endmodule

// ===== status_reporting_service_request_test.sv
module status_reporting_service_request_test
  import status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [8:0] EXE = 9'h001, PRS = 9'h002, RDE = 9'h004, LOST = 9'h008;
  localparam logic [8:0] MST = 9'h010, MDN = 9'h020, FET = 9'h040;
  localparam logic [8:0] PNOW = 9'h080, FLSH = 9'h100;

  logic        sys_clk, sys_rst, ieee_mode, cmd_valid;
  cmd_type     cmd_code;
  logic [15:0] cmd_data, rsp_data, r;
  logic        rsp_valid, ops_idle, meas_by_init, ques_summary;
  logic        poll_req, poll_valid, srq, opc_push, oq_has_data, auto_poll;
  logic [7:0]  poll_data, opc_push_data;
  logic [3:0]  delay;
  logic [8:0]  ev;
  int          fail_count, check_count, cycles;
  logic [15:0] rsp_q[$];
  logic [7:0]  poll_q[$], push_q[$];
  cmd_type     zq[5] = '{CMD_ESE_Q, CMD_SRE_Q, CMD_OEN_Q, CMD_OCOND_Q, CMD_OEVT_Q};

  status_reporting_service_request status_reporting_service_request_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .ieee_mode(ieee_mode),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .exec_error(ev[0]), .parse_error(ev[1]), .oq_read_empty(ev[2]),
    .oq_data_lost(ev[3]), .oq_has_data(oq_has_data), .ops_idle(ops_idle),
    .meas_start(ev[4]), .meas_done(ev[5]), .meas_by_init(meas_by_init),
    .fetch_done(ev[6]), .ques_summary(ques_summary), .poll_req(poll_req),
    .poll_valid(poll_valid), .poll_data(poll_data), .srq(srq),
    .opc_push(opc_push), .opc_push_data(opc_push_data));

  host_ctrl_model host_ctrl_model_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .srq(srq), .opc_push(opc_push),
    .auto_poll(auto_poll), .delay(delay), .poll_now(ev[7]),
    .oq_flush(ev[8]), .poll_req(poll_req), .oq_has_data(oq_has_data));

  always #5 sys_clk = ~sys_clk;

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic cmd(input cmd_type c, input logic [15:0] d);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_code  <= c;
    cmd_data  <= d;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
  endtask

  // The reply is noted first so the watcher finds it when rsp_valid appears
  task automatic query(input cmd_type c, input logic [15:0] e);
    rsp_q.push_back(e);
    cmd(c, 16'h0000);
  endtask

  task automatic pulse(input logic [8:0] m);
    @(posedge sys_clk);
    ev <= m;
    @(posedge sys_clk);
    ev <= '0;
  endtask

  task automatic poll(input logic [7:0] e);
    poll_q.push_back(e);
    pulse(PNOW);
    idle(3);
  endtask

  task automatic wait_srq(input logic v);
    int i;
    for (i = 0; i < 50 && srq !== v; i++) @(posedge sys_clk);
    chk("srq", {15'h0000, v}, {15'h0000, srq});
  endtask

  task automatic done(input string n);
    $display("Test %s done", n);
  endtask

  // Watcher: each result takes the oldest note; a result with no note compares to unknown
  always @(posedge sys_clk) begin
    if (rsp_valid === 1'b1)
      chk("rsp_data", rsp_q.size() != 0 ? rsp_q.pop_front() : 16'hxxxx, rsp_data);
    if (poll_valid === 1'b1)
      chk("poll_data", {8'h00, poll_q.size() != 0 ? poll_q.pop_front() : 8'hxx},
          {8'h00, poll_data});
    if (opc_push === 1'b1)
      chk("opc_push_data", {8'h00, push_q.size() != 0 ? push_q.pop_front() : 8'hxx},
          {8'h00, opc_push_data});
  end

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      close_out();
    end
  end

  initial begin
    sys_clk = 1'b0; sys_rst = 1'b1; ieee_mode = 1'b1; cmd_valid = 1'b0;
    cmd_code = CMD_NONE; cmd_data = 16'h0000; ev = '0; ops_idle = 1'b1;
    meas_by_init = 1'b0; ques_summary = 1'b0; auto_poll = 1'b0; delay = 4'h0;
    void'($urandom(32'ha735_9842));
    idle(8);
    sys_rst <= 1'b0;
    query(CMD_ESR_Q, 16'h0080);
    query(CMD_ESR_Q, 16'h0000);
    foreach (zq[i]) query(zq[i], 16'h0000);
    done("reset");
    pulse(EXE | PRS | RDE);
    query(CMD_ESR_Q, 16'h0034);
    pulse(LOST);
    query(CMD_ESR_Q, 16'h0004);
    ieee_mode <= 1'b0;
    pulse(RDE | LOST);
    query(CMD_ESR_Q, 16'h0000);
    ieee_mode <= 1'b1;
    done("errors");
    for (int k = 0; k < 4; k++) begin
      r = 16'($urandom);
      cmd(CMD_ESE_W, r);
      query(CMD_ESE_Q, {8'h00, r[7:0] & SE_USED});
      cmd(CMD_SRE_W, r);
      query(CMD_SRE_Q, {8'h00, r[7:0] & 8'hBF});
      cmd(CMD_OEN_W, r);
      query(CMD_OEN_Q, r & OP_USED);
    end
    done("masks");
    cmd(CMD_ESE_W, 16'h0001);
    cmd(CMD_SRE_W, 16'h0020);
    cmd(CMD_OEN_W, 16'h0000);
    cmd(CMD_CLS, 16'h0000);
    ops_idle <= 1'b0;
    cmd(CMD_OPC, 16'h0000);
    idle(4);
    chk("srq", 16'h0000, {15'h0000, srq});
    ops_idle <= 1'b1;
    wait_srq(1'b1);
    query(CMD_STB_Q, 16'h0060);
    poll(8'h60);
    chk("srq", 16'h0000, {15'h0000, srq});
    poll(8'h20);
    query(CMD_STB_Q, 16'h0060);
    query(CMD_ESR_Q, 16'h0001);
    query(CMD_STB_Q, 16'h0000);
    cmd(CMD_OPC, 16'h0000);
    wait_srq(1'b1);
    query(CMD_ESR_Q, 16'h0001);
    idle(2);
    chk("srq", 16'h0000, {15'h0000, srq});
    auto_poll <= 1'b1;
    delay <= 4'h5;
    poll_q.push_back(8'h60);
    cmd(CMD_OPC, 16'h0000);
    wait_srq(1'b1);
    wait_srq(1'b0);
    auto_poll <= 1'b0;
    query(CMD_ESR_Q, 16'h0001);
    done("service_request");
    cmd(CMD_SRE_W, 16'h0080);
    cmd(CMD_OEN_W, 16'h0110);
    meas_by_init <= 1'b1;
    pulse(MST);
    idle(3);
    query(CMD_OCOND_Q, 16'h0010);
    query(CMD_OCOND_Q, 16'h0010);
    chk("srq", 16'h0001, {15'h0000, srq});
    query(CMD_STB_Q, 16'h00C0);
    pulse(MDN);
    idle(3);
    query(CMD_OCOND_Q, 16'h0100);
    query(CMD_OEVT_Q, 16'h0110);
    query(CMD_OEVT_Q, 16'h0000);
    idle(2);
    chk("srq", 16'h0000, {15'h0000, srq});
    query(CMD_STB_Q, 16'h0000);
    pulse(FET);
    idle(2);
    query(CMD_OCOND_Q, 16'h0000);
    meas_by_init <= 1'b0;
    pulse(MST);
    pulse(MDN);
    idle(3);
    query(CMD_OEVT_Q, 16'h0010);
    done("operation");
    cmd(CMD_SRE_W, 16'h0010);
    ops_idle <= 1'b0;
    cmd(CMD_OPC_Q, 16'h0000);
    idle(3);
    query(CMD_STB_Q, 16'h0000);
    push_q.push_back(OPC_REPLY);
    ops_idle <= 1'b1;
    idle(5);
    query(CMD_STB_Q, 16'h0050);
    pulse(FLSH);
    idle(2);
    query(CMD_STB_Q, 16'h0000);
    ops_idle <= 1'b0;
    cmd(CMD_OPC_Q, 16'h0000);
    cmd(CMD_OPC, 16'h0000);
    cmd(CMD_CLS, 16'h0000);
    ops_idle <= 1'b1;
    idle(5);
    query(CMD_ESR_Q, 16'h0000);
    query(CMD_STB_Q, 16'h0000);
    done("completion");
    cmd(CMD_ESE_W, 16'h0020);
    ieee_mode <= 1'b0;
    ques_summary <= 1'b1;
    cmd(CMD_OPC, 16'h0000);
    cmd(CMD_OPC_Q, 16'h0000);
    idle(2);
    query(CMD_STB_Q, 16'h0028);
    chk("srq", 16'h0000, {15'h0000, srq});
    query(CMD_ESR_Q, 16'h0020);
    ques_summary <= 1'b0;
    idle(2);
    query(CMD_STB_Q, 16'h0000);
    done("serial");
    ieee_mode <= 1'b1;
    pulse(EXE | PRS);
    cmd(CMD_CLS, 16'h0000);
    query(CMD_ESR_Q, 16'h0000);
    query(CMD_STB_Q, 16'h0000);
    done("clear");
    idle(6);
    chk("notes_left", 16'h0000, 16'(rsp_q.size() + poll_q.size() + push_q.size()));
    close_out();
  end
endmodule
